/* File: logic/evg_pkg.sv */
// Purpose: constants for the event interrupt grouping block
// Assumes: APB slave, 32-bit data, registers are 16-bit words in the low lanes
// Notes: register indices are word indices; byte address is four times the index
package evg_pkg;

    // ****************************************
    // register indices
    // ****************************************
    localparam logic [15:0] EVG_IDX_MASK_A = 16'h742C;
    localparam logic [15:0] EVG_IDX_MASK_B = 16'h742D;
    localparam logic [15:0] EVG_IDX_MASK_C = 16'h742E;
    localparam logic [15:0] EVG_IDX_FLAG_A = 16'h742F;
    localparam logic [15:0] EVG_IDX_FLAG_B = 16'h7430;
    localparam logic [15:0] EVG_IDX_FLAG_C = 16'h7431;
    localparam logic [15:0] EVG_IDX_VEC_A = 16'h7432;
    localparam logic [15:0] EVG_IDX_VEC_B = 16'h7433;
    localparam logic [15:0] EVG_IDX_VEC_C = 16'h7434;

    // ****************************************
    // group sizes, ids and reset values
    // ****************************************
    localparam int EVG_NUM_A = 11;
    localparam int EVG_NUM_B = 8;
    localparam int EVG_NUM_C = 4;
    localparam logic [5:0] EVG_BASE_ID_A = 6'h20;
    localparam logic [5:0] EVG_BASE_ID_B = 6'h2B;
    localparam logic [5:0] EVG_BASE_ID_C = 6'h33;
    localparam logic [5:0] EVG_NO_ID = 6'h00;
    localparam int EVG_VEC_W = 6;
    localparam logic [31:0] EVG_RDATA_RESET = 32'h0000_0000;

endpackage : evg_pkg

/* File: logic/evg_top.sv */
// Purpose: three interrupt groups with flag, mask and vector registers on APB
// Assumes: event inputs are one-cycle pulses from logic on clk
// Notes: every APB access takes one wait state
//
// Contract
// - three groups with flag, mask, vector
// - groups drive core lines two, three, four
// - masked flag raises no group request
// - six-bit vector per group names highest pending
// - group A eleven sources, ids 20h-2Ah
// - group B eight sources, ids 2Bh-32h
// - group C four captures, ids 33h-36h
// - events set flags even when masked
// - request when some unmasked flag pending
// - vector read returns highest set flag id
// - vector read clears the returned flag
// - write one clears flag, zero keeps
// - vector reads zero with no flags
// - 16-bit registers, unused bits read zero
// - group A flags bit0 highest to bit10
// - all flags reset to zero
// - vector in bits 5-0, rest zero
//
// Added by the designer: the APB slave port.
`timescale 1ns/100ps

// ****************************************
// one interrupt group
// ****************************************
module evg_group
    import evg_pkg::*;
#(
    parameter int N = 4,
    parameter logic [5:0] BASE = 6'h00
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [N-1:0] event_in,
    input wire logic mask_we,
    input wire logic [N-1:0] mask_wdata,
    input wire logic flag_we,
    input wire logic [N-1:0] flag_wdata,
    input wire logic claim,
    input wire logic [N-1:0] claim_sel,
    output logic [N-1:0] flags,
    output logic [N-1:0] group_enable_masks,
    output logic [N-1:0] top_sel,
    output logic [EVG_VEC_W-1:0] vector_id,
    output logic irq_n
);
    logic [N-1:0] next_flags;
    logic [N-1:0] next_mask;
    logic next_irq_n;

    // ****************************************
    // priority scan
    // ****************************************
    // bit 0 is highest priority, so scan from the top down
    always_comb begin
        vector_id = EVG_NO_ID;
        top_sel = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (flags[i]) begin
                vector_id = BASE + EVG_VEC_W'(i);
                top_sel = N'(1) << i;
            end
        end
    end

    // ****************************************
    // next flags, mask and request
    // ****************************************
    // masks gate only the request line, never the flags or the vector
    always_comb begin
        next_flags = flags;
        if (flag_we) begin
            next_flags = next_flags & ~flag_wdata;
        end
        if (claim) begin
            next_flags = next_flags & ~claim_sel;
        end
        next_flags = next_flags | event_in;
        next_mask = mask_we ? mask_wdata : group_enable_masks;
        // one high cycle after a claim gives the core a fresh falling edge
        next_irq_n = claim | ~(|(flags & group_enable_masks));
    end

    // ****************************************
    // group registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flags <= '0;
            group_enable_masks <= '0;
            irq_n <= 1'b1;
        end else begin
            flags <= next_flags;
            group_enable_masks <= next_mask;
            irq_n <= next_irq_n;
        end
    end
endmodule : evg_group

// ****************************************
// top with APB slave
// ****************************************
module evg_top
    import evg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [EVG_NUM_A-1:0] event_a,
    input wire logic [EVG_NUM_B-1:0] event_b,
    input wire logic [EVG_NUM_C-1:0] event_c,
    output logic core_irq_line_two_n,
    output logic core_irq_line_three_n,
    output logic core_irq_line_four_n
);
    logic [EVG_NUM_A-1:0] flags_a;
    logic [EVG_NUM_B-1:0] flags_b;
    logic [EVG_NUM_C-1:0] flags_c;
    logic [EVG_NUM_A-1:0] mask_a;
    logic [EVG_NUM_B-1:0] mask_b;
    logic [EVG_NUM_C-1:0] mask_c;
    logic [EVG_NUM_A-1:0] top_a;
    logic [EVG_NUM_B-1:0] top_b;
    logic [EVG_NUM_C-1:0] top_c;
    logic [EVG_VEC_W-1:0] vec_a;
    logic [EVG_VEC_W-1:0] vec_b;
    logic [EVG_VEC_W-1:0] vec_c;
    logic [EVG_NUM_A-1:0] claim_a_sel;
    logic [EVG_NUM_B-1:0] claim_b_sel;
    logic [EVG_NUM_C-1:0] claim_c_sel;
    logic [EVG_NUM_A-1:0] next_claim_a_sel;
    logic [EVG_NUM_B-1:0] next_claim_b_sel;
    logic [EVG_NUM_C-1:0] next_claim_c_sel;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic hit_mask_a, hit_mask_b, hit_mask_c;
    logic hit_flag_a, hit_flag_b, hit_flag_c;
    logic hit_vec_a, hit_vec_b, hit_vec_c;
    logic hit_any;
    logic access_wait;
    logic access_done;
    logic wr_done;
    logic rd_done;

    // ****************************************
    // address decode
    // ****************************************
    function automatic logic addr_is(input logic [31:0] a, input logic [15:0] idx);
        addr_is = (a == {14'h0000, idx, 2'b00});
    endfunction : addr_is

    always_comb begin
        hit_mask_a = addr_is(paddr, EVG_IDX_MASK_A);
        hit_mask_b = addr_is(paddr, EVG_IDX_MASK_B);
        hit_mask_c = addr_is(paddr, EVG_IDX_MASK_C);
        hit_flag_a = addr_is(paddr, EVG_IDX_FLAG_A);
        hit_flag_b = addr_is(paddr, EVG_IDX_FLAG_B);
        hit_flag_c = addr_is(paddr, EVG_IDX_FLAG_C);
        hit_vec_a = addr_is(paddr, EVG_IDX_VEC_A);
        hit_vec_b = addr_is(paddr, EVG_IDX_VEC_B);
        hit_vec_c = addr_is(paddr, EVG_IDX_VEC_C);
        hit_any = hit_mask_a | hit_mask_b | hit_mask_c | hit_flag_a | hit_flag_b
            | hit_flag_c | hit_vec_a | hit_vec_b | hit_vec_c;
        access_wait = psel & penable & ~pready;
        access_done = psel & penable & pready;
        wr_done = access_done & pwrite;
        rd_done = access_done & ~pwrite;
    end

    // ****************************************
    // read data and answer
    // ****************************************
    // the claimed flag is frozen with the read data, so the cleared flag
    // is exactly the one whose id went out even if a new event lands
    always_comb begin
        next_prdata = prdata;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        next_claim_a_sel = claim_a_sel;
        next_claim_b_sel = claim_b_sel;
        next_claim_c_sel = claim_c_sel;
        if (access_wait) begin
            next_pready = 1'b1;
            next_pslverr = ~hit_any;
            next_prdata = EVG_RDATA_RESET;
            if (hit_mask_a) begin
                next_prdata[EVG_NUM_A-1:0] = mask_a;
            end
            if (hit_mask_b) begin
                next_prdata[EVG_NUM_B-1:0] = mask_b;
            end
            if (hit_mask_c) begin
                next_prdata[EVG_NUM_C-1:0] = mask_c;
            end
            if (hit_flag_a) begin
                next_prdata[EVG_NUM_A-1:0] = flags_a;
            end
            if (hit_flag_b) begin
                next_prdata[EVG_NUM_B-1:0] = flags_b;
            end
            if (hit_flag_c) begin
                next_prdata[EVG_NUM_C-1:0] = flags_c;
            end
            if (hit_vec_a) begin
                next_prdata[EVG_VEC_W-1:0] = vec_a;
            end
            if (hit_vec_b) begin
                next_prdata[EVG_VEC_W-1:0] = vec_b;
            end
            if (hit_vec_c) begin
                next_prdata[EVG_VEC_W-1:0] = vec_c;
            end
            next_claim_a_sel = top_a;
            next_claim_b_sel = top_b;
            next_claim_c_sel = top_c;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prdata <= EVG_RDATA_RESET;
            pready <= 1'b0;
            pslverr <= 1'b0;
            claim_a_sel <= '0;
            claim_b_sel <= '0;
            claim_c_sel <= '0;
        end else begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            claim_a_sel <= next_claim_a_sel;
            claim_b_sel <= next_claim_b_sel;
            claim_c_sel <= next_claim_c_sel;
        end
    end

    // ****************************************
    // groups
    // ****************************************
    // three independent groups; A, B, C feed lines two to four
    evg_group #(.N(EVG_NUM_A), .BASE(EVG_BASE_ID_A)) u_group_a (
        .clk(clk),
        .rst_n(rst_n),
        .event_in(event_a),
        .mask_we(wr_done & hit_mask_a),
        .mask_wdata(pwdata[EVG_NUM_A-1:0]),
        .flag_we(wr_done & hit_flag_a),
        .flag_wdata(pwdata[EVG_NUM_A-1:0]),
        .claim(rd_done & hit_vec_a),
        .claim_sel(claim_a_sel),
        .flags(flags_a),
        .group_enable_masks(mask_a),
        .top_sel(top_a),
        .vector_id(vec_a),
        .irq_n(core_irq_line_two_n)
    );

    evg_group #(.N(EVG_NUM_B), .BASE(EVG_BASE_ID_B)) u_group_b (
        .clk(clk),
        .rst_n(rst_n),
        .event_in(event_b),
        .mask_we(wr_done & hit_mask_b),
        .mask_wdata(pwdata[EVG_NUM_B-1:0]),
        .flag_we(wr_done & hit_flag_b),
        .flag_wdata(pwdata[EVG_NUM_B-1:0]),
        .claim(rd_done & hit_vec_b),
        .claim_sel(claim_b_sel),
        .flags(flags_b),
        .group_enable_masks(mask_b),
        .top_sel(top_b),
        .vector_id(vec_b),
        .irq_n(core_irq_line_three_n)
    );

    evg_group #(.N(EVG_NUM_C), .BASE(EVG_BASE_ID_C)) u_group_c (
        .clk(clk),
        .rst_n(rst_n),
        .event_in(event_c),
        .mask_we(wr_done & hit_mask_c),
        .mask_wdata(pwdata[EVG_NUM_C-1:0]),
        .flag_we(wr_done & hit_flag_c),
        .flag_wdata(pwdata[EVG_NUM_C-1:0]),
        .claim(rd_done & hit_vec_c),
        .claim_sel(claim_c_sel),
        .flags(flags_c),
        .group_enable_masks(mask_c),
        .top_sel(top_c),
        .vector_id(vec_c),
        .irq_n(core_irq_line_four_n)
    );
endmodule : evg_top

/* File: verification/evg_core_model.sv */
// Purpose: model of the core side of the three request lines
// Assumes: lines are active low, index 0 is the highest priority
// Notes: accepts one request per cycle
`timescale 1ns/100ps
module evg_core_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] line_n,
    input wire logic global_irq_disable,
    input wire logic [2:0] core_irq_mask,
    input wire logic [2:0] sw_clear,
    output logic [2:0] core_pending_flags,
    output logic [2:0] taken
);
    logic [2:0] line_q;
    logic [2:0] next_pend;
    logic [2:0] next_taken;
    always_comb begin
        next_taken = 3'h0;
        for (int i = 0; i < 3; i++) begin
            if (next_taken == 3'h0 && core_pending_flags[i] && core_irq_mask[i]
                && !global_irq_disable) begin
                next_taken[i] = 1'b1;
            end
        end
        // a new falling edge survives an accept of the old one
        next_pend = (core_pending_flags & ~next_taken & ~sw_clear) | (line_q & ~line_n);
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            core_pending_flags <= 3'h0;
            taken <= 3'h0;
            line_q <= 3'h7;
        end else begin
            core_pending_flags <= next_pend;
            taken <= next_taken;
            line_q <= line_n;
        end
    end
endmodule : evg_core_model

/* File: verification/evg_top_asserts.sv */
// Purpose: port checker for the interrupt grouping block
// Assumes: one clock, synchronous active-low reset
// Notes: bound to evg_top after the module
`timescale 1ns/100ps
module evg_top_asserts
    import evg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic core_irq_line_two_n,
    input wire logic core_irq_line_three_n,
    input wire logic core_irq_line_four_n
);
    // ****************************************
    // protocol and vector checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence answer_s;
        !pready ##1 pready ##1 !pready;
    endsequence
    sequence vec_rd_s(logic [31:0] a);
        pready && !pwrite && paddr == a;
    endsequence
    one_wait_a: assert property ($rose(psel && penable) |-> answer_s)
        else $error("access not answered after one wait");
    err_pair_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    unmapped_read_a: assert property ($rose(psel && penable) && !pwrite && paddr == 32'h0
        |-> ##1 pslverr && prdata == 32'h0) else $error("unmapped read not refused");
    mapped_ok_a: assert property (pready && paddr == 32'h0001D0BC |-> !pslverr)
        else $error("mapped flag access refused");
    upper_zero_a: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    vec_a_range_a: assert property (vec_rd_s(32'h0001D0C8)
        |-> prdata == 32'h0 || (prdata >= 32'h20 && prdata <= 32'h2A)) else $error("bad id A");
    vec_c_range_a: assert property (vec_rd_s(32'h0001D0D0)
        |-> prdata == 32'h0 || (prdata >= 32'h33 && prdata <= 32'h36)) else $error("bad id C");
    vec_release_a: assert property (vec_rd_s(32'h0001D0C8) |=> core_irq_line_two_n)
        else $error("line two not released after vector read");
    reset_idle_a: assert property ($rose(rst_n) |-> !pready && core_irq_line_two_n
        && core_irq_line_three_n && core_irq_line_four_n) else $error("not idle after reset");
endmodule : evg_top_asserts

bind evg_top evg_top_asserts evg_top_asserts_i (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .core_irq_line_two_n(core_irq_line_two_n),
    .core_irq_line_three_n(core_irq_line_three_n), .core_irq_line_four_n(core_irq_line_four_n));

/* File: verification/evg_top_tb.sv */
// Purpose: register and request tests for the interrupt grouping block
// Assumes: one wait state per access, waited for by pready
// Notes: core side is the behavioural model
`timescale 1ns/100ps
module evg_top_tb
    import evg_pkg::*;
;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
    logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
    logic [10:0] event_a = 0;
    logic [7:0] event_b = 0;
    logic [3:0] event_c = 0;
    logic core_irq_line_two_n, core_irq_line_three_n, core_irq_line_four_n;
    logic global_irq_disable = 1;
    logic [2:0] pend, clr = 0;
    int fails = 0, samples_checked = 0, cycles = 0;

    evg_top evg_top_i (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .event_a(event_a), .event_b(event_b), .event_c(event_c),
        .core_irq_line_two_n(core_irq_line_two_n),
        .core_irq_line_three_n(core_irq_line_three_n),
        .core_irq_line_four_n(core_irq_line_four_n));
    evg_core_model evg_core_model_i (.clk(clk), .rst_n(rst_n),
        .line_n({core_irq_line_four_n, core_irq_line_three_n, core_irq_line_two_n}),
        .global_irq_disable(global_irq_disable), .core_irq_mask(3'h7), .sw_clear(clr),
        .core_pending_flags(pend), .taken());

    // ****************************************
    // bus and compare tasks
    // ****************************************
    always #20 clk = ~clk;

    task summarize;
        if (fails == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : summarize

    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            fails++;
            summarize;
        end
    end

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task bus(input logic [15:0] idx, input logic w, input logic [31:0] d);
        @(posedge clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= {14'h0, idx, 2'b00};
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : bus

    task ev(input logic [10:0] a, input logic [7:0] b, input logic [3:0] c);
        @(posedge clk);
        event_a <= a;
        event_b <= b;
        event_c <= c;
        @(posedge clk);
        event_a <= 0;
        event_b <= 0;
        event_c <= 0;
    endtask : ev

    // one id per read in falling priority, then zero
    task drain(input logic [15:0] idx, input logic [5:0] base, input int n);
        for (int i = 0; i <= n; i++) begin
            bus(idx, 0, 0);
            chk("vector", (i == n) ? 32'h0 : 32'(base) + 32'(i), rd);
        end
    endtask : drain

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1;
        bus(EVG_IDX_FLAG_A, 0, 0);
        chk("flag_a", 32'h0, rd);
        ev('1, '1, '1);
        repeat (2) @(posedge clk);
        chk("lines", 32'h7,
            32'({core_irq_line_four_n, core_irq_line_three_n, core_irq_line_two_n}));
        bus(EVG_IDX_FLAG_A, 0, 0);
        chk("flag_a", 32'h7FF, rd);
        bus(EVG_IDX_FLAG_B, 0, 0);
        chk("flag_b", 32'hFF, rd);
        bus(EVG_IDX_FLAG_C, 0, 0);
        chk("flag_c", 32'hF, rd);
        drain(EVG_IDX_VEC_A, EVG_BASE_ID_A, EVG_NUM_A);
        drain(EVG_IDX_VEC_B, EVG_BASE_ID_B, EVG_NUM_B);
        drain(EVG_IDX_VEC_C, EVG_BASE_ID_C, EVG_NUM_C);
        ev(0, '1, 0);
        bus(EVG_IDX_FLAG_B, 1, 32'h0001FF0F);
        bus(EVG_IDX_FLAG_B, 0, 0);
        chk("flag_b", 32'hF0, rd);
        bus(EVG_IDX_MASK_A, 1, '1);
        bus(EVG_IDX_MASK_A, 0, 0);
        chk("mask_a", 32'h7FF, rd);
        bus(16'h0000, 0, 0);
        chk("slverr", 32'h1, 32'(err));
        ev(11'h001, 0, 0);
        repeat (3) @(posedge clk);
        chk("pending", 32'h1, 32'(pend));
        global_irq_disable <= 0;
        repeat (3) @(posedge clk);
        chk("pending", 32'h0, 32'(pend));
        drain(EVG_IDX_VEC_A, EVG_BASE_ID_A, 1);
        global_irq_disable <= 1;
        bus(EVG_IDX_MASK_B, 1, 32'h1);
        ev(0, 8'h01, 0);
        repeat (3) @(posedge clk);
        chk("pending", 32'h2, 32'(pend));
        clr <= 3'h2;
        @(posedge clk);
        clr <= 0;
        @(posedge clk);
        chk("pending", 32'h0, 32'(pend));
        bus(EVG_IDX_MASK_C, 1, 32'h1);
        event_c <= 4'h1;
        bus(EVG_IDX_FLAG_C, 1, 32'h1);
        event_c <= 4'h0;
        bus(EVG_IDX_FLAG_C, 0, 0);
        chk("flag_c", 32'h1, rd);
        chk("pending", 32'h4, 32'(pend));
        drain(EVG_IDX_VEC_C, EVG_BASE_ID_C, 1);
        summarize;
    end
endmodule : evg_top_tb
